// ===== core/csf_pkg.sv
package csf_pkg;

  // ---------------------------------------------------------------
  // Register map and fields
  // ---------------------------------------------------------------
  localparam int AXI_ADDR_W = 8;
  localparam logic [7:0] ADDR_OSC_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_UNLOCK_KEY = 8'h04;
  localparam logic [7:0] ADDR_OSC_STATUS = 8'h08;
  localparam int CUR_SEL_LSB = 12;
  localparam int NEW_SEL_LSB = 8;
  localparam int LOCK_BIT = 5;
  localparam int FAIL_BIT = 3;
  localparam int KEEP_LP_BIT = 1;
  localparam int SWEN_BIT = 0;
  localparam int STAT_RUN_LSB = 0;
  localparam int STAT_PLL_BIT = 4;
  localparam int STAT_STATE_LSB = 8;
  localparam int STAT_ENABLED_BIT = 16;
  localparam logic [7:0] KEY_HIGH_BYTE = 8'h9a;
  localparam logic [7:0] KEY_LOW_BYTE = 8'h3c;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // Source select codes and submodes
  // ---------------------------------------------------------------
  localparam logic [2:0] SEL_FAST_RC = 3'h0;
  localparam logic [2:0] SEL_FAST_RC_PLL = 3'h1;
  localparam logic [2:0] SEL_PRIMARY = 3'h2;
  localparam logic [2:0] SEL_PRIMARY_PLL = 3'h3;
  localparam logic [2:0] SEL_SECONDARY = 3'h4;
  localparam logic [2:0] SEL_SLOW_RC = 3'h5;
  localparam logic [2:0] SEL_FAST_RC_DIV16 = 3'h6;
  localparam logic [2:0] SEL_FAST_RC_DIVN = 3'h7;
  localparam logic [1:0] SUB_HS_CRYSTAL = 2'h2;
  localparam logic [1:0] SUB_CRYSTAL = 2'h1;
  localparam logic [1:0] SUB_EXTERNAL = 2'h0;
  localparam int NUM_SRC = 4;
  localparam logic [1:0] SRC_FAST = 2'h0;
  localparam logic [1:0] SRC_PRIMARY = 2'h1;
  localparam logic [1:0] SRC_SECOND = 2'h2;
  localparam logic [1:0] SRC_SLOW = 2'h3;

  // ---------------------------------------------------------------
  // Timing counts
  // ---------------------------------------------------------------
  localparam logic [3:0] NEW_CLK_WAIT = 4'ha;
  localparam int STARTUP_CYCLES_DEF = 1024;
  localparam int FAIL_REF_EDGES_DEF = 4;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START = 3'b001,
    ST_STARTUP = 3'b010,
    ST_PLL_WAIT = 3'b011,
    ST_WAIT_NEW = 3'b100,
    ST_SWAP = 3'b101
  } csf_state_type;

  function automatic logic [1:0] src_of(input logic [2:0] sel);
    case (sel)
      SEL_PRIMARY, SEL_PRIMARY_PLL: src_of = SRC_PRIMARY;
      SEL_SECONDARY: src_of = SRC_SECOND;
      SEL_SLOW_RC: src_of = SRC_SLOW;
      default: src_of = SRC_FAST;
    endcase
  endfunction

  function automatic logic uses_pll(input logic [2:0] sel);
    uses_pll = (sel == SEL_FAST_RC_PLL) || (sel == SEL_PRIMARY_PLL);
  endfunction

endpackage

// ===== core/csf_edge_sync.sv
`timescale 1ns/1ps
module csf_edge_sync #(
  parameter int WIDTH = 5
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
    logic [WIDTH-1:0] prev;
    logic [WIDTH-1:0] rise;
  } csf_sync_type;

  csf_sync_type q;
  csf_sync_type d;
  logic [WIDTH-1:0] rise_next;

  // Edge detection looks only at the second stage and its delayed copy.
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    assign rise_next[i] = q.sync[i] & ~q.prev[i];
  end

  always_comb begin
    d = q;
    d.meta = async_in;
    d.sync = q.meta;
    d.prev = q.sync;
    d.rise = rise_next;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign level = q.sync;
  assign rise = q.rise;

endmodule

// ===== core/csf_fail_monitor.sv
`timescale 1ns/1ps
module csf_fail_monitor #(
  parameter int REF_EDGES = 4
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic enable,
  input wire logic restart,
  input wire logic ref_edge,
  input wire logic watch_edge,
  output logic fail
);

  typedef struct packed {
    logic [7:0] cnt;
    logic fail;
  } csf_mon_type;

  csf_mon_type q;
  csf_mon_type d;

  // Reference edges without any activity of the watched clock mean loss.
  always_comb begin
    d = q;
    d.fail = 1'b0;
    if (!enable || restart || watch_edge) begin
      d.cnt = 8'h00;
    end else if (ref_edge) begin
      if (q.cnt == 8'(REF_EDGES - 1)) begin
        d.fail = 1'b1;
        d.cnt = 8'h00;
      end else begin
        d.cnt = q.cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign fail = q.fail;

endmodule

// ===== core/csf_clock_switch_failsafe.sv
// The register addresses and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
module csf_clock_switch_failsafe #(
  parameter int STARTUP_CYCLES = csf_pkg::STARTUP_CYCLES_DEF,
  parameter int FAIL_REF_EDGES = csf_pkg::FAIL_REF_EDGES_DEF
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic clock_switch_monitor_cfg,
  input wire logic [2:0] initial_osc_select_cfg,
  input wire logic [1:0] primary_submode_cfg,
  input wire logic watchdog_enable,
  input wire logic sleep_mode,
  input wire logic [3:0] osc_activity,
  input wire logic pll_lock,
  output logic [3:0] osc_run,
  output logic pll_run,
  output logic [2:0] sys_clk_select,
  output logic clock_fail_trap
);

  typedef struct packed {
    logic awready;
    logic wready;
    logic arready;
    logic aw_hold;
    logic [7:0] aw_addr;
    logic w_hold;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic unlock_hi;
    logic unlock_lo;
    logic init_done;
    logic [2:0] cur_sel;
    logic [2:0] new_sel;
    logic swen;
    logic lock;
    logic cf;
    logic keep_lp;
    csf_pkg::csf_state_type state;
    logic [15:0] timer;
    logic [3:0] edge_cnt;
    logic [3:0] osc_run;
    logic pll_run;
    logic trap;
  } csf_main_type;

  csf_main_type q;
  csf_main_type d;
  logic [4:0] sync_level;
  logic [4:0] sync_rise;
  logic lock_sync;
  logic fail_evt;
  logic sw_enabled;
  logic mon_enable;
  logic mon_restart;
  logic cur_pll;
  logic [1:0] cur_src;
  logic [1:0] new_src;

  // ---------------------------------------------------------------
  // Oscillator activity, PLL lock and failure monitor
  // ---------------------------------------------------------------
  csf_edge_sync #(
    .WIDTH(5)
  ) u_sync (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .async_in({pll_lock, osc_activity}),
    .level(sync_level),
    .rise(sync_rise)
  );

  assign lock_sync = sync_level[4];
  assign sw_enabled = !clock_switch_monitor_cfg;
  assign cur_src = csf_pkg::src_of(q.cur_sel);
  assign new_src = csf_pkg::src_of(q.new_sel);
  assign cur_pll = csf_pkg::uses_pll(q.cur_sel);
  // Slow RC cannot watch itself, so monitoring pauses while it is the system clock.
  assign mon_enable = sw_enabled && q.init_done && !sleep_mode && (cur_src != csf_pkg::SRC_SLOW);
  assign mon_restart = q.trap || (q.state == csf_pkg::ST_SWAP);

  csf_fail_monitor #(
    .REF_EDGES(FAIL_REF_EDGES)
  ) u_mon (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .enable(mon_enable),
    .restart(mon_restart),
    .ref_edge(sync_rise[csf_pkg::SRC_SLOW]),
    .watch_edge(sync_rise[cur_src]),
    .fail(fail_evt)
  );

  // ---------------------------------------------------------------
  // Register access, switch sequence and fail-safe
  // ---------------------------------------------------------------
  always_comb begin
    logic [31:0] rd;
    logic crystal;
    rd = 32'h0000_0000;
    crystal = 1'b0;
    d = q;
    d.trap = 1'b0;
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (s_axi_awvalid && q.awready) begin
      d.aw_hold = 1'b1;
      d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready) begin
      d.w_hold = 1'b1;
      d.w_data = s_axi_wdata;
      d.w_strb = s_axi_wstrb;
    end
    if (d.aw_hold && d.w_hold && !d.bvalid) begin
      d.aw_hold = 1'b0;
      d.w_hold = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = csf_pkg::RESP_OKAY;
      d.unlock_hi = 1'b0;
      d.unlock_lo = 1'b0;
      case (d.aw_addr)
        csf_pkg::ADDR_UNLOCK_KEY: begin
          if (d.w_strb[0] && d.w_data[7:0] == csf_pkg::KEY_HIGH_BYTE) begin
            d.unlock_hi = 1'b1;
          end
          if (d.w_strb[0] && d.w_data[7:0] == csf_pkg::KEY_LOW_BYTE) begin
            d.unlock_lo = 1'b1;
          end
        end
        csf_pkg::ADDR_OSC_CONTROL: begin
          if (d.w_strb[1] && q.unlock_hi && sw_enabled && q.state == csf_pkg::ST_IDLE) begin
            d.new_sel = d.w_data[csf_pkg::NEW_SEL_LSB +: 3];
          end
          if (d.w_strb[0] && q.unlock_lo) begin
            d.keep_lp = d.w_data[csf_pkg::KEEP_LP_BIT];
            if (!d.w_data[csf_pkg::FAIL_BIT]) begin
              d.cf = 1'b0;
            end
            if (d.w_data[csf_pkg::SWEN_BIT] && sw_enabled && q.state == csf_pkg::ST_IDLE) begin
              d.swen = 1'b1;
              d.state = csf_pkg::ST_START;
            end
          end
        end
        csf_pkg::ADDR_OSC_STATUS: begin
        end
        default: begin
          d.bresp = csf_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (s_axi_arvalid && q.arready) begin
      d.rvalid = 1'b1;
      d.rresp = csf_pkg::RESP_OKAY;
      case (s_axi_araddr)
        csf_pkg::ADDR_OSC_CONTROL: begin
          rd[csf_pkg::CUR_SEL_LSB +: 3] = q.cur_sel;
          rd[csf_pkg::NEW_SEL_LSB +: 3] = q.new_sel;
          rd[csf_pkg::LOCK_BIT] = q.lock;
          rd[csf_pkg::FAIL_BIT] = q.cf;
          rd[csf_pkg::KEEP_LP_BIT] = q.keep_lp;
          rd[csf_pkg::SWEN_BIT] = q.swen;
        end
        csf_pkg::ADDR_OSC_STATUS: begin
          rd[csf_pkg::STAT_RUN_LSB +: 4] = q.osc_run;
          rd[csf_pkg::STAT_PLL_BIT] = q.pll_run;
          rd[csf_pkg::STAT_STATE_LSB +: 3] = q.state;
          rd[csf_pkg::STAT_ENABLED_BIT] = sw_enabled;
        end
        csf_pkg::ADDR_UNLOCK_KEY: begin
        end
        default: begin
          d.rresp = csf_pkg::RESP_SLVERR;
        end
      endcase
      d.rdata = rd;
    end

    // The system clock select changes only at the swap, at a failure trap, which ends the
    // sequence, or from configuration at init or while switching is disabled, so the core stays on the old clock for the whole sequence.
    crystal = ((new_src == csf_pkg::SRC_PRIMARY) &&
               (primary_submode_cfg != csf_pkg::SUB_EXTERNAL)) ||
              (new_src == csf_pkg::SRC_SECOND);
    case (q.state)
      csf_pkg::ST_IDLE: begin
        d.lock = q.pll_run && lock_sync;
      end
      csf_pkg::ST_START: begin
        d.edge_cnt = 4'h0;
        if (q.new_sel == q.cur_sel) begin
          d.swen = 1'b0;
          d.state = csf_pkg::ST_IDLE;
        end else begin
          d.lock = 1'b0;
          d.cf = 1'b0;
          if (crystal && !q.osc_run[new_src]) begin
            d.timer = 16'(STARTUP_CYCLES - 1);
            d.state = csf_pkg::ST_STARTUP;
          end else if (csf_pkg::uses_pll(q.new_sel)) begin
            d.state = csf_pkg::ST_PLL_WAIT;
          end else begin
            d.state = csf_pkg::ST_WAIT_NEW;
          end
        end
      end
      csf_pkg::ST_STARTUP: begin
        if (q.timer == 16'h0000) begin
          d.state = csf_pkg::uses_pll(q.new_sel) ? csf_pkg::ST_PLL_WAIT : csf_pkg::ST_WAIT_NEW;
        end else begin
          d.timer = q.timer - 16'h0001;
        end
      end
      csf_pkg::ST_PLL_WAIT: begin
        if (lock_sync) begin
          d.lock = 1'b1;
          d.state = csf_pkg::ST_WAIT_NEW;
        end
      end
      csf_pkg::ST_WAIT_NEW: begin
        if (sync_rise[new_src]) begin
          d.edge_cnt = q.edge_cnt + 4'h1;
          if (q.edge_cnt == csf_pkg::NEW_CLK_WAIT - 4'h1) begin
            d.state = csf_pkg::ST_SWAP;
          end
        end
      end
      csf_pkg::ST_SWAP: begin
        d.cur_sel = q.new_sel;
        d.swen = 1'b0;
        d.state = csf_pkg::ST_IDLE;
      end
      default: begin
        d.state = csf_pkg::ST_IDLE;
      end
    endcase

    if (sw_enabled && fail_evt) begin
      d.trap = 1'b1;
      d.cf = 1'b1;
      d.cur_sel = cur_pll ? csf_pkg::SEL_FAST_RC_PLL : csf_pkg::SEL_FAST_RC;
      d.new_sel = d.cur_sel;
      d.swen = 1'b0;
      d.state = csf_pkg::ST_IDLE;
    end
    if (!q.init_done || !sw_enabled) begin
      d.init_done = 1'b1;
      d.cur_sel = initial_osc_select_cfg;
      d.new_sel = initial_osc_select_cfg;
      d.swen = 1'b0;
      d.state = csf_pkg::ST_IDLE;
    end

    // Submode is never stored here, so it follows configuration alone.
    d.osc_run = 4'h0;
    d.osc_run[csf_pkg::src_of(d.cur_sel)] = d.init_done;
    if (d.state != csf_pkg::ST_IDLE) begin
      d.osc_run[csf_pkg::src_of(d.new_sel)] = 1'b1;
    end
    if ((watchdog_enable || sw_enabled) && !sleep_mode) begin
      d.osc_run[csf_pkg::SRC_SLOW] = 1'b1;
    end
    if (d.keep_lp) begin
      d.osc_run[csf_pkg::SRC_SECOND] = 1'b1;
    end
    d.pll_run = d.init_done && (csf_pkg::uses_pll(d.cur_sel) ||
                ((d.state != csf_pkg::ST_IDLE) && csf_pkg::uses_pll(d.new_sel)));
    d.awready = !d.aw_hold && !d.bvalid;
    d.wready = !d.w_hold && !d.bvalid;
    d.arready = !d.rvalid;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bresp = q.bresp;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_arready = q.arready;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign s_axi_rvalid = q.rvalid;
  assign osc_run = q.osc_run;
  assign pll_run = q.pll_run;
  assign sys_clk_select = q.cur_sel;
  assign clock_fail_trap = q.trap;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  chk_swen_disabled: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clock_switch_monitor_cfg |=> !q.swen)
    else $error("switch enable set while switching disabled");
  chk_cur_from_cfg: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clock_switch_monitor_cfg && q.init_done |=> q.cur_sel == $past(initial_osc_select_cfg))
    else $error("current select does not follow configuration");
  chk_redundant_abort: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (q.state == csf_pkg::ST_START) && (q.new_sel == q.cur_sel) && sw_enabled
    |=> (q.state == csf_pkg::ST_IDLE) && !q.swen)
    else $error("redundant switch not abandoned");
  chk_flags_cleared: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (q.state == csf_pkg::ST_START) && (q.new_sel != q.cur_sel) && !fail_evt && sw_enabled
    |=> !q.lock && !q.cf)
    else $error("lock or fail flag not cleared at switch start");
  chk_startup_count: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (q.state == csf_pkg::ST_STARTUP) && (q.timer != 16'h0000) && !fail_evt && sw_enabled
    |=> (q.state == csf_pkg::ST_STARTUP) && (q.timer == $past(q.timer) - 16'h0001))
    else $error("startup timer left early");
  chk_pll_wait: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (q.state == csf_pkg::ST_PLL_WAIT) && !lock_sync && !fail_evt && sw_enabled
    |=> q.state == csf_pkg::ST_PLL_WAIT)
    else $error("left PLL wait without lock");
  chk_ten_edges: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (q.state == csf_pkg::ST_SWAP) |-> (q.edge_cnt == csf_pkg::NEW_CLK_WAIT))
    else $error("swap without ten new clock edges");
  chk_swap_done: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (q.state == csf_pkg::ST_SWAP) && !fail_evt && sw_enabled
    |=> (q.cur_sel == $past(q.new_sel)) && !q.swen && (sys_clk_select == q.cur_sel))
    else $error("swap did not update current select");
  chk_fail_fallback: assert property (@(posedge sys_clk) disable iff (!rst_b)
    fail_evt && sw_enabled && q.init_done
    |=> clock_fail_trap && q.cf &&
        (q.cur_sel == ($past(cur_pll) ? csf_pkg::SEL_FAST_RC_PLL : csf_pkg::SEL_FAST_RC)))
    else $error("failure did not trap to fast RC");
  chk_slow_rc_on: assert property (@(posedge sys_clk) disable iff (!rst_b)
    sw_enabled && q.init_done && !sleep_mode |=> osc_run[csf_pkg::SRC_SLOW])
    else $error("slow RC stopped while monitor enabled");

endmodule

// ===== verif/csf_testbench.sv
`timescale 1ns/1ps
module testbench;
  localparam logic [7:0] CTL = csf_pkg::ADDR_OSC_CONTROL;
  localparam logic [7:0] KEY = csf_pkg::ADDR_UNLOCK_KEY;
  logic sys_clk = 1'h0;
  logic rst_b = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata, rd;
  logic [3:0] wstrb = 4'h0, act = 4'h0, act_en = 4'hf, run, lock_cnt = 4'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, pll_run, trap, pll_lock = 1'h0;
  logic cfg = 1'h0, wdog = 1'h1, kp = 1'h0, slp = 1'h0;
  logic [1:0] bresp, rresp, resp, submode = 2'h1, slow_div = 2'h0;
  logic [2:0] sel, init_sel = 3'h0, t;
  logic [2:0] seq [10] = '{3'h2, 3'h3, 3'h0, 3'h1, 3'h5, 3'h4, 3'h6, 3'h7, 3'h0, 3'h0};
  logic [31:0] seed = 32'h0add_e901;
  int err_total = 0, n_checks = 0, cyc = 0, cur_m = 0;

  csf_clock_switch_failsafe #(.STARTUP_CYCLES(4), .FAIL_REF_EDGES(4)) DUT (
    .sys_clk(sys_clk), .rst_b(rst_b), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .clock_switch_monitor_cfg(cfg), .initial_osc_select_cfg(init_sel),
    .primary_submode_cfg(submode), .watchdog_enable(wdog), .sleep_mode(slp),
    .osc_activity(act), .pll_lock(pll_lock), .osc_run(run), .pll_run(pll_run),
    .sys_clk_select(sel), .clock_fail_trap(trap));

  // ---------------------------------------------------------------
  // Clock, oscillators and PLL
  // ---------------------------------------------------------------
  always #12.5 sys_clk = ~sys_clk;

  // Each source toggles only while enabled; the slow RC has a period of eight clocks.
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    slow_div <= slow_div + 2'h1;
    for (int i = 0; i < 3; i++)
      if (run[i] && act_en[i]) act[i] <= ~act[i];
    if (run[3] && act_en[3] && slow_div == 2'h0) act[3] <= ~act[3];
    lock_cnt <= !pll_run ? 4'h0 : (lock_cnt == 4'hf) ? lock_cnt : lock_cnt + 4'h1;
    pll_lock <= (lock_cnt > 4'h7);
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic int src(input int s);
    return (s == 2 || s == 3) ? 1 : (s == 4) ? 2 : (s == 5) ? 3 : 0;
  endfunction

  task chk(input bit ok, input string m);
    n_checks++;
    if (!ok) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask

  task tally_and_finish();
    if (err_total == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    resp = 2'h3;
    while (resp === 2'h3) begin
      @(posedge sys_clk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      if (bvalid) begin
        resp = bresp;
        bready <= 1'h0;
      end
    end
  endtask

  task axr(input logic [7:0] a);
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    resp = 2'h3;
    while (resp === 2'h3) begin
      @(posedge sys_clk);
      if (arvalid && arready) arvalid <= 1'h0;
      if (rvalid) begin
        resp = rresp;
        rd = rdata;
        rready <= 1'h0;
      end
    end
  endtask

  task do_reset(input logic c, input logic [2:0] i);
    @(posedge sys_clk);
    rst_b <= 1'h0;
    cfg <= c;
    init_sel <= i;
    submode <= 2'(rnd() % 3);
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'h1;
    repeat (3) @(posedge sys_clk);
    cur_m = i;
    chk(sel === i, "initial source wrong");
    if (!c) chk(run[3] === 1'h1, "slow RC stopped with monitor on");
    axr(csf_pkg::ADDR_OSC_STATUS);
    chk(rd[16] === !c, "switching enable state wrong");
  endtask

  // ---------------------------------------------------------------
  // One complete software switch with its model update
  // ---------------------------------------------------------------
  task do_switch(input logic [2:0] tg);
    int t0;
    logic [2:0] old;
    old = 3'(cur_m);
    if (!cfg) cur_m = tg;
    axw(KEY, {24'h00_0000, csf_pkg::KEY_HIGH_BYTE}, 4'h1);
    axw(CTL, {21'h0_0000, tg, 8'h00}, 4'h2);
    axw(KEY, {24'h00_0000, csf_pkg::KEY_LOW_BYTE}, 4'h1);
    kp = 1'(rnd());
    axw(CTL, {28'h000_0000, 2'h2, kp, 1'h1}, 4'h1);
    t0 = cyc;
    rd = 32'h0000_0001;
    while (rd[0] !== 1'h0 && cyc - t0 < 2000) begin
      axr(CTL);
      if (rd[0] === 1'h1) chk(rd[14:12] === old, "select moved early");
    end
    chk(rd[0] === 1'h0, "enable not cleared");
    chk(rd[14:12] === 3'(cur_m) && sel === 3'(cur_m), "current select wrong");
    if (!cfg && tg != old) begin
      chk(cyc - t0 >= 18, "changed before ten new clocks");
      chk(rd[3] === 1'h0, "fail flag not cleared");
      if (tg == 3'h1 || tg == 3'h3) chk(rd[5] === 1'h1, "lock flag low");
      repeat (2) @(posedge sys_clk);
      chk(run[src(tg)] === 1'h1, "new source off");
      if (src(old) != src(tg))
        chk(run[src(old)] === (src(old) == 3 || (src(old) == 2 && kp)),
            "old source state");
    end
    chk(pll_run === (cur_m == 1 || cur_m == 3), "PLL enable wrong");
    chk(run[2] === (kp || src(cur_m) == 2), "secondary run state");
  endtask

  // Walks sleep and watchdog through all four combinations and checks the slow RC enable.
  task slow_rc_scan();
    for (int k = 0; k < 4; k++) begin
      slp <= 1'(k);
      wdog <= 1'(k >> 1);
      repeat (3) @(posedge sys_clk);
      chk(run[3] === (src(cur_m) == 3 || (!slp && (wdog || !cfg))), "slow RC state");
    end
    wdog <= 1'h1;
    slp <= 1'h0;
  endtask

  task fail_case(input logic [2:0] from, input logic [2:0] to);
    int n;
    n = 0;
    do_switch(from);
    act_en <= ~(4'h1 << src(from));
    while (trap !== 1'h1 && n < 300) begin
      @(posedge sys_clk);
      n++;
    end
    chk(trap === 1'h1, "no failure trap");
    repeat (3) @(posedge sys_clk);
    act_en <= 4'hf;
    cur_m = to;
    chk(sel === to, "wrong fallback source");
    axr(CTL);
    chk(rd[3] === 1'h1 && rd[14:12] === to, "fail flag not set");
  endtask

  // ---------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    do_reset(1'h0, 3'h0);
    axr(8'h0c);
    chk(resp === csf_pkg::RESP_SLVERR && rd === 32'h0000_0000, "unmapped read");
    axw(CTL, 32'h0000_0700, 4'h2);
    axr(CTL);
    chk(rd[10:8] === 3'h0, "locked byte written");
    foreach (seq[k]) do_switch(seq[k]);
    repeat (6) begin
      t = 3'(rnd());
      if ((cur_m == 1 && t == 3'h3) || (cur_m == 3 && t == 3'h1)) t = 3'h0;
      do_switch(t);
    end
    slow_rc_scan();
    do_switch(3'h0);
    fail_case(3'h3, 3'h1);
    do_switch(3'h0);
    fail_case(3'h2, 3'h0);
    fail_case(3'h4, 3'h0);
    do_reset(1'h1, 3'(rnd()));
    do_switch(3'(cur_m + 1));
    act_en <= 4'h0;
    repeat (100) begin
      @(posedge sys_clk);
      chk(trap === 1'h0, "trap while disabled");
    end
    slow_rc_scan();
    tally_and_finish();
  end

  initial begin
    repeat (60000) @(posedge sys_clk);
    err_total++;
    tally_and_finish();
  end
endmodule
